// ### hdl/olw_consts.svh
`ifndef OLW_CONSTS_SVH
`define OLW_CONSTS_SVH

`define OLW_COLS 8'h84
`define OLW_MSG_COLS 8'h60
`define OLW_INIT_LEN 4'h6
`define OLW_STROBE_CYCLES 4'h4
`define OLW_CMD_PAGE_BASE 8'hB0
`define OLW_CMD_COL_LO 8'h00
`define OLW_CMD_COL_HI 8'h10
`define OLW_CMD_SCROLL_SETUP 8'h26
`define OLW_CMD_SCROLL_ON 8'h2F
`define OLW_CMD_DISPLAY_ON 8'hAF
`define OLW_ADDR_LAST 4'h2
`define OLW_SCROLL_LAST 4'h5
`define OLW_MODE_SEL_A 1'b1
`define OLW_MODE_SEL_B 1'b1
`define OLW_RW_WRITE 1'b0
`define OLW_DC_DATA 1'b1
`define OLW_DC_CMD 1'b0

`endif

// ### hdl/olw_pkg.sv
`default_nettype none
package olw_pkg;
  typedef enum logic [5:0] {
    OLW_ST_IDLE = 6'b00_0000,
    OLW_ST_INIT = 6'b00_0001,
    OLW_ST_CLR_ADDR = 6'b00_0010,
    OLW_ST_CLR_DATA = 6'b00_0011,
    OLW_ST_WAIT1 = 6'b00_0100,
    OLW_ST_MSG_ADDR = 6'b00_0101,
    OLW_ST_MSG_DATA = 6'b00_0110,
    OLW_ST_WAIT2 = 6'b00_0111,
    OLW_ST_SCROLL = 6'b00_1000,
    OLW_ST_DONE = 6'b00_1001
  } olw_state_t;

  typedef struct packed {
    logic dc;
    logic [7:0] data;
  } olw_xfer_t;

  typedef struct packed {
    logic cs_n;
    logic dc;
    logic rw;
    logic en;
    logic mode_a;
    logic mode_b;
    logic [7:0] data;
  } olw_bus_t;
endpackage : olw_pkg
`default_nettype wire

// ### hdl/olw_writer.sv
`include "olw_consts.svh"
`default_nettype none
// Contract
// RULE1 - Two pages: upper and lower eight rows
// RULE2 - Clear all 132 columns of both pages
// RULE3 - Init values are constants, sent on the first press
// RULE4 - Message from two constant per-page arrays
// RULE5 - Parallel interface only, not serial
// RULE6 - Read/write select low means write
// RULE7 - Chip select active low
// RULE8 - Eight-bit parallel output bus
// RULE9 - Six-bit state debug output
// RULE10 - Data/command high data, low command
// RULE11 - Active-low asynchronous board reset
// RULE12 - First press initializes and shows message
// RULE13 - Second press scrolls; later presses ignored
// RULE14 - Set dc and byte, select, pulse enable
// RULE15 - Mode selects fixed at parallel levels
module olw_writer #(
  parameter int STROBE_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic trigger_button,
  output olw_pkg::olw_bus_t bus,
  output logic [5:0] state_debug,
  output logic init_done
);
  olw_pkg::olw_state_t state_reg, state_next;
  logic btn_s1_reg, btn_s2_reg, btn_d_reg;
  logic [7:0] col_reg, col_next;
  logic page_reg, page_next;
  logic [3:0] idx_reg, idx_next;
  logic [3:0] ph_reg;
  logic busy_reg;
  logic start;
  olw_pkg::olw_xfer_t xf;
  olw_pkg::olw_bus_t bus_reg;

  function automatic logic [7:0] init_byte(input logic [3:0] i);
    unique case (i)
      4'h0: init_byte = `OLW_CMD_DISPLAY_ON;
      4'h1: init_byte = 8'hA1;
      4'h2: init_byte = 8'hC8;
      4'h3: init_byte = 8'hA6;
      4'h4: init_byte = 8'hA4;
      default: init_byte = 8'h40;
    endcase
  endfunction : init_byte

  // Message arrays, one per page; each bit is one pixel
  function automatic logic [7:0] msg_byte(input logic pg, input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (c[7:3] == 5'h05 || c[7:3] == 5'h07) begin
      v = pg ? 8'h0F : 8'hF0; // RULE4
    end else if (c[2:0] == 3'h0) begin
      v = pg ? 8'h3C : 8'hFF; // RULE4
    end
    msg_byte = v;
  endfunction : msg_byte

  // Button sync and rising edge; first stage read only by second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      btn_s1_reg <= 1'b0;
      btn_s2_reg <= 1'b0;
      btn_d_reg <= 1'b0;
    end else begin
      btn_s1_reg <= trigger_button;
      btn_s2_reg <= btn_s1_reg;
      btn_d_reg <= btn_s2_reg;
    end
  end
  wire press = btn_s2_reg & ~btn_d_reg;
  wire last_ph = (ph_reg == 4'(STROBE_CYCLES - 1));
  wire xfer_end = busy_reg & last_ph;
  wire col_last = (col_reg == `OLW_COLS - 8'h01);
  wire msg_last = (col_reg == `OLW_MSG_COLS - 8'h01);
  wire [7:0] page_cmd = `OLW_CMD_PAGE_BASE | {7'h00, page_reg}; // RULE1

  // Byte selection for the current state
  always_comb begin
    xf.dc = `OLW_DC_CMD;
    xf.data = 8'h00;
    start = 1'b0;
    unique case (state_reg)
      olw_pkg::OLW_ST_INIT: begin
        xf.data = init_byte(idx_reg); // RULE3
        start = 1'b1;
      end
      olw_pkg::OLW_ST_CLR_ADDR, olw_pkg::OLW_ST_MSG_ADDR: begin
        xf.data = (idx_reg == 4'h0) ? page_cmd :
                  (idx_reg == 4'h1) ? `OLW_CMD_COL_LO : `OLW_CMD_COL_HI;
        start = 1'b1;
      end
      olw_pkg::OLW_ST_CLR_DATA: begin
        xf.dc = `OLW_DC_DATA; // RULE10
        xf.data = 8'h00; // RULE2
        start = 1'b1;
      end
      olw_pkg::OLW_ST_MSG_DATA: begin
        xf.dc = `OLW_DC_DATA; // RULE10
        xf.data = msg_byte(page_reg, col_reg); // RULE4
        start = 1'b1;
      end
      olw_pkg::OLW_ST_SCROLL: begin
        xf.data = (idx_reg == 4'h0) ? `OLW_CMD_SCROLL_SETUP :
                  (idx_reg == `OLW_SCROLL_LAST) ? `OLW_CMD_SCROLL_ON : 8'h00;
        start = 1'b1;
      end
      default: ;
    endcase
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    col_next = col_reg;
    page_next = page_reg;
    idx_next = idx_reg;
    unique case (state_reg)
      olw_pkg::OLW_ST_IDLE:
        if (press) begin
          state_next = olw_pkg::OLW_ST_INIT; // RULE12
          idx_next = 4'h0;
        end
      olw_pkg::OLW_ST_INIT:
        if (xfer_end) begin
          idx_next = idx_reg + 4'h1;
          if (idx_reg == `OLW_INIT_LEN - 4'h1) begin
            state_next = olw_pkg::OLW_ST_CLR_ADDR;
            idx_next = 4'h0;
            page_next = 1'b0;
          end
        end
      olw_pkg::OLW_ST_CLR_ADDR, olw_pkg::OLW_ST_MSG_ADDR:
        if (xfer_end) begin
          idx_next = idx_reg + 4'h1;
          col_next = 8'h00;
          if (idx_reg == `OLW_ADDR_LAST) begin
            idx_next = 4'h0;
            state_next = (state_reg == olw_pkg::OLW_ST_CLR_ADDR) ?
              olw_pkg::OLW_ST_CLR_DATA : olw_pkg::OLW_ST_MSG_DATA;
          end
        end
      olw_pkg::OLW_ST_CLR_DATA:
        if (xfer_end) begin
          col_next = col_reg + 8'h01;
          if (col_last) begin // RULE2
            page_next = ~page_reg;
            state_next = page_reg ? olw_pkg::OLW_ST_MSG_ADDR :
                                    olw_pkg::OLW_ST_CLR_ADDR;
          end
        end
      olw_pkg::OLW_ST_MSG_DATA:
        if (xfer_end) begin
          col_next = col_reg + 8'h01;
          if (msg_last) begin
            page_next = ~page_reg;
            state_next = page_reg ? olw_pkg::OLW_ST_WAIT2 :
                                    olw_pkg::OLW_ST_MSG_ADDR;
          end
        end
      olw_pkg::OLW_ST_WAIT2:
        if (press) begin
          state_next = olw_pkg::OLW_ST_SCROLL; // RULE13
          idx_next = 4'h0;
        end
      olw_pkg::OLW_ST_SCROLL:
        if (xfer_end) begin
          idx_next = idx_reg + 4'h1;
          if (idx_reg == `OLW_SCROLL_LAST) begin
            state_next = olw_pkg::OLW_ST_DONE; // RULE13
          end
        end
      default: ;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= olw_pkg::OLW_ST_IDLE; // RULE11
      col_reg <= 8'h00;
      page_reg <= 1'b0;
      idx_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      col_reg <= col_next;
      page_reg <= page_next;
      idx_reg <= idx_next;
    end
  end

  // Transfer phases: 0 setup with select, 1..N-2 enable high, N-1 hold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      ph_reg <= last_ph ? 4'h0 : ph_reg + 4'h1;
      busy_reg <= ~last_ph;
    end else if (start) begin
      busy_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_reg.cs_n <= 1'b1; // RULE7
      bus_reg.dc <= `OLW_DC_CMD;
      bus_reg.rw <= `OLW_RW_WRITE;
      bus_reg.en <= 1'b0;
      bus_reg.mode_a <= `OLW_MODE_SEL_A;
      bus_reg.mode_b <= `OLW_MODE_SEL_B;
      bus_reg.data <= 8'h00;
    end else begin
      bus_reg.cs_n <= ~(busy_reg & ~last_ph); // RULE7 RULE14
      bus_reg.dc <= xf.dc; // RULE10 RULE14
      bus_reg.rw <= `OLW_RW_WRITE; // RULE6
      bus_reg.en <= busy_reg && ph_reg != 4'h0 && !last_ph; // RULE14
      bus_reg.mode_a <= `OLW_MODE_SEL_A; // RULE5 RULE15
      bus_reg.mode_b <= `OLW_MODE_SEL_B; // RULE15
      bus_reg.data <= xf.data; // RULE8 RULE14
    end
  end

  assign bus = bus_reg;
  assign state_debug = state_reg; // RULE9
  assign init_done = (state_reg == olw_pkg::OLW_ST_WAIT2) ||
                     (state_reg == olw_pkg::OLW_ST_SCROLL) ||
                     (state_reg == olw_pkg::OLW_ST_DONE);
endmodule : olw_writer
`default_nettype wire

// ### bench/olw_disp_model.sv
`default_nettype none
module olw_disp_model (
  input wire logic clk,
  input wire olw_pkg::olw_bus_t bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got[$];
  logic en_q = 1'b0;
  // Latch one byte on each rising strobe while selected for write
  always @(posedge clk) begin
    en_q <= bus.en;
    if (bus.en && !en_q && !bus.cs_n && !bus.rw) begin
      got.push_back({bus.dc, bus.data});
    end
  end
endmodule : olw_disp_model
`default_nettype wire

// ### bench/olw_writer_props.sv
`default_nettype none
module olw_writer_props #(
  parameter int STROBE_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic trigger_button,
  input wire olw_pkg::olw_bus_t bus,
  input wire logic [5:0] state_debug,
  input wire logic init_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  int sel_cnt;
  // Counts the cycles of each select window
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_cnt <= 0;
    end else begin
      sel_cnt <= bus.cs_n ? 0 : sel_cnt + 1;
    end
  end
  AST_SEL_WIDTH: assert property ($rose(bus.cs_n) |->
    sel_cnt == STROBE_CYCLES - 1)
    else $error("select width");
  AST_RW_WRITE: assert property (!bus.rw)
    else $error("rw high");
  AST_MODE_FIXED: assert property (bus.mode_a && bus.mode_b)
    else $error("mode select");
  AST_EN_SELECT: assert property (bus.en |-> !bus.cs_n)
    else $error("strobe unselected");
  AST_EN_PULSE: assert property ($rose(bus.en) |-> bus.en [*2] ##1 !bus.en)
    else $error("strobe width");
  AST_HOLD: assert property (!bus.cs_n && !$past(bus.cs_n) |->
    $stable(bus.data) && $stable(bus.dc))
    else $error("byte moved");
  AST_DONE_MAP: assert property (init_done ==
    (state_debug inside {6'h07, 6'h08, 6'h09}))
    else $error("done flag");
  AST_IDLE_QUIET: assert property (state_debug == 6'h00 |-> bus.cs_n)
    else $error("idle select");
  AST_DONE_STAY: assert property (state_debug == 6'h09 |=>
    state_debug == 6'h09 && bus.cs_n)
    else $error("left done");
  COV_INIT: cover property ($rose(init_done));
  COV_CLEAR: cover property (state_debug == 6'h03 && bus.en);
  COV_DONE: cover property (state_debug == 6'h09 && trigger_button);
endmodule : olw_writer_props
bind olw_writer olw_writer_props #(.STROBE_CYCLES(STROBE_CYCLES)) u_props (
  .clk(clk), .reset_n(reset_n), .trigger_button(trigger_button),
  .bus(bus), .state_debug(state_debug), .init_done(init_done));
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic trig = 1'b0;
  olw_pkg::olw_bus_t bus;
  logic [5:0] st;
  logic idone;
  logic [31:0] rnd = 32'hd573_e0ff;
  int errors = 0;
  int total_checks = 0;
  int ex[$];
  olw_writer dut (.clk(clk), .reset_n(reset_n), .trigger_button(trig),
    .bus(bus), .state_debug(st), .init_done(idone));
  olw_disp_model u_disp (.clk(clk), .bus(bus));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic fail(string m);
    errors++;
    $display("ERROR %0t %s", $time, m);
  endtask : fail
  task automatic chk_byte(logic [8:0] g, int e);
    total_checks++;
    if (e[9] ? (g !== e[8:0]) : (g[8] !== e[8])) fail("bus byte");
  endtask : chk_byte
  task automatic chk_state(logic [5:0] g, logic [5:0] e);
    total_checks++;
    if (g !== e) fail("state code");
  endtask : chk_state
  task automatic chk_flag(logic g, logic e);
    total_checks++;
    if (g !== e) fail("done flag");
  endtask : chk_flag
  task automatic chk_num(int g, int e);
    total_checks++;
    if (g != e) fail("byte count");
  endtask : chk_num
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic put(int full, int dc, int d);
    ex.push_back((full << 9) | (dc << 8) | d);
  endtask : put
  task automatic press();
    rnd = lfsr(rnd);
    trig <= 1'b1;
    repeat (4 + rnd[2:0]) @(posedge clk);
    trig <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : press
  task automatic wait_st(logic [5:0] s);
    int n;
    n = 0;
    while (st !== s && n < 8000) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    chk_state(st, s);
    chk_flag(idone, s >= 6'h07);
    chk_num(u_disp.got.size(), ex.size());
    for (int i = 0; i < ex.size() && i < u_disp.got.size(); i++)
      chk_byte(u_disp.got[i], ex[i]);
    u_disp.got = {};
    ex = {};
  endtask : wait_st
  task automatic run_init();
    repeat (6) put(0, 0, 0);
    for (int p = 0; p < 2; p++) begin
      put(1, 0, 8'hB0 + p);
      put(1, 0, 8'h00);
      put(1, 0, 8'h10);
      repeat (132) put(1, 1, 0);
    end
    for (int p = 0; p < 2; p++) begin
      put(1, 0, 8'hB0 + p);
      put(1, 0, 8'h00);
      put(1, 0, 8'h10);
      repeat (96) put(0, 1, 0);
    end
    press();
    repeat (60) @(posedge clk);
    press();
    wait_st(6'h07);
  endtask : run_init
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    run_init();
    put(1, 0, 8'h26);
    repeat (4) put(1, 0, 0);
    put(1, 0, 8'h2F);
    press();
    press();
    wait_st(6'h09);
    press();
    wait_st(6'h09);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_state(st, 6'h00);
    chk_flag(idone, 1'b0);
    reset_n <= 1'b1;
    run_init();
    give_verdict();
  end
  initial begin
    #2_000_000;
    fail("timeout");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
